// file: lscd_core.sv
// Purpose: digital core of a 160-output lcd segment/common driver
// Assumes: pins sampled by i_clk through two flip-flops
// Notes: pin strobes are edge-detected after synchronisation
// Operation
// - stay selected until 160 bits taken
// - four-bit mode pairs two nibbles per byte
// - eight-bit mode takes one byte per clock
// - latch pointer steps every 16 bits
// - twenty byte transfers fill one line
// - latch falling edge copies all 160 bits
// - common mode shifts on latch falling edge
// - latch pulse restarts input sequencing
// - segment level table by polarity, bit
// - common level table by polarity, bit
// - blanking low forces V5 everywhere
// - four-bit order and chain port roles
// - eight-bit output ordering by direction
// - single common shift direction and ports
// - 120-output option skips outputs 61-100
// - dual mode: two halves, bit7 feeds second
// - chain output low one shift clock
// - blanking clears line latch, keeps loading
// - select high means segment mode
`timescale 1ns/1ns
module lscd_core #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_pixel_shift_clock,
    input wire logic i_line_latch_pulse,
    input wire logic i_frame_polarity,
    input wire logic i_output_blank_n,
    input wire logic [7:0] i_pixel_data_in,
    input wire lscd_pkg::lscd_mode_t i_mode,
    input wire logic i_chain_port_a,
    output logic o_chain_port_a,
    output logic o_chain_port_a_oe,
    input wire logic i_chain_port_b,
    output logic o_chain_port_b,
    output logic o_chain_port_b_oe,
    output logic [2*lscd_pkg::OUTS-1:0] o_driver_outputs
);
    import lscd_pkg::*;

    // two-flop synchronisers for all pins
    localparam int NS = 18;
    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    logic [1:0] s3;
    wire [NS-1:0] pins = {i_pixel_shift_clock, i_line_latch_pulse,
        i_frame_polarity, i_output_blank_n, i_pixel_data_in,
        i_mode, i_chain_port_a, i_chain_port_b};
    always_ff @(posedge i_clk)
    begin
        s1 <= pins;
        s2 <= s1;
        s3 <= s2[NS-1:NS-2];
    end
    wire pixel_shift_clock = s2[17];
    wire lp = s2[16];
    wire fr = s2[15];
    wire blank_n = s2[14];
    wire [7:0] din = s2[13:6];
    lscd_mode_t md;
    assign md = s2[5:2];
    wire port_a = s2[1];
    wire port_b = s2[0];
    wire xck_fall = s3[1] && !pixel_shift_clock;
    wire lp_fall = s3[0] && !lp;
    wire seg = md.seg_mode;
    wire right = md.dir_right;
    // chain input follows direction: low -> port b in, port a out
    wire chain_in = right ? port_a : port_b;

    // segment input sequencing
    lscd_seq_t state;
    lscd_seq_t next_state;
    logic [7:0] bit_cnt;
    logic [4:0] byte_cnt;
    logic nib_half;
    logic [3:0] nib_hold;
    logic chain_low;
    wire take = (state == SEQ_LOAD) && xck_fall && seg;
    wire [7:0] bits_step = md.width_or_dual ? 8'h08 : 8'h04;
    wire [7:0] next_bits = bit_cnt + bits_step;
    wire line_full = take && next_bits >= 8'(OUTS);
    always_comb
    begin
        next_state = state;
        case (state)
            SEQ_WAIT: if (seg && !chain_in) next_state = SEQ_LOAD;
            SEQ_LOAD: if (line_full) next_state = SEQ_DONE;
            SEQ_DONE: next_state = SEQ_DONE;
            default: next_state = SEQ_WAIT;
        endcase
        if (lp_fall)
            next_state = SEQ_WAIT;
    end

    // nibble pairing or full byte capture
    // first nibble of a pair lands in the upper half of the byte
    logic fifo_rdy;
    wire byte_ok = take && fifo_rdy
        && (md.width_or_dual || nib_half);
    wire [7:0] byte_val = md.width_or_dual ? din :
        {nib_hold, din[3:0]};
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n || lp_fall)
        begin
            state <= SEQ_WAIT;
            bit_cnt <= CNT_ZERO;
            nib_half <= 1'b0;
            nib_hold <= 4'h0;
        end
        else
        begin
            state <= next_state;
            if (take)
            begin
                bit_cnt <= next_bits;
                nib_half <= !nib_half;
                nib_hold <= din[3:0];
            end
        end
    end

    // chain output pulses low for one shift clock after the last bit
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n || lp_fall)
            chain_low <= 1'b0;
        else if (line_full)
            chain_low <= 1'b1;
        else if (xck_fall)
            chain_low <= 1'b0;
    end

    // byte fifo into the data latch writer
    logic f_valid;
    logic [7:0] f_data;
    lscd_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_flush(lp_fall && state != SEQ_DONE && !f_valid),
        .i_valid(byte_ok),
        .o_ready(fifo_rdy),
        .i_data(byte_val),
        .o_valid(f_valid),
        .i_ready(1'b1),
        .o_data(f_data)
    );

    // data latch: 10 groups of 16 bits, pointer advances per group
    logic [OUTS-1:0] dlatch;
    logic [3:0] grp_ptr;
    logic grp_half;
    wire [3:0] grp_idx = right ? grp_ptr : 4'(OUTS/GROUP_BITS - 1) - grp_ptr;
    // direction high: first byte pixel_data_in -> y8..y1; low: y153..y160
    wire [7:0] rev_byte = {f_data[0], f_data[1], f_data[2], f_data[3],
        f_data[4], f_data[5], f_data[6], f_data[7]};
    wire [7:0] put = right ? rev_byte : f_data;
    wire [7:0] slot = {grp_idx, 4'h0} + (right ? {4'h0, grp_half, 3'h0}
        : {4'h0, !grp_half, 3'h0});
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            dlatch <= '0;
            grp_ptr <= 4'h0;
            grp_half <= 1'b0;
            byte_cnt <= BYTE_ZERO;
        end
        else if (lp_fall && !f_valid)
        begin
            grp_ptr <= 4'h0;
            grp_half <= 1'b0;
            byte_cnt <= BYTE_ZERO;
        end
        else if (f_valid && byte_cnt < 5'(BYTES_PER_LINE))
        begin
            dlatch[slot +: 8] <= put;
            byte_cnt <= byte_cnt + 5'h01;
            grp_half <= !grp_half;
            if (grp_half)
                grp_ptr <= grp_ptr + 4'h1;
        end
    end

    // line latch or common shift register
    logic [OUTS-1:0] line;
    logic [OUTS-1:0] next_line;
    wire dual = md.width_or_dual;
    wire cut = md.out120 && !dual;
    always_comb
    begin
        next_line = line;
        if (right)
        begin
            next_line = {line[OUTS-2:0], chain_in};
            if (dual)
                next_line[HALF] = din[7];
            if (cut)
                next_line[SKIP_HI] = line[SKIP_LO-1];
        end
        else
        begin
            next_line = {chain_in, line[OUTS-1:1]};
            if (dual)
                next_line[HALF-1] = din[7];
            if (cut)
                next_line[SKIP_LO-1] = line[SKIP_HI];
        end
        if (cut)
            next_line[SKIP_HI-1:SKIP_LO] = '0;
    end
    wire com_out = right ? line[OUTS-1] : line[0];
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n || !blank_n)
            line <= '0;
        else if (lp_fall)
            line <= seg ? dlatch : next_line;
    end

    // chain pins: out port has enable, in port released
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_chain_port_a <= 1'b1;
            o_chain_port_b <= 1'b1;
            o_chain_port_a_oe <= 1'b0;
            o_chain_port_b_oe <= 1'b0;
        end
        else
        begin
            o_chain_port_a <= seg ? !chain_low : com_out;
            o_chain_port_b <= seg ? !chain_low : com_out;
            o_chain_port_a_oe <= !right;
            o_chain_port_b_oe <= right;
        end
    end

    // four-level output code per driver
    wire [2*OUTS-1:0] codes;
    genvar g;
    generate
        for (g = 0; g < OUTS; g++)
        begin : g_lvl
            logic [1:0] code;
            always_comb
            begin
                case ({fr, line[g]})
                    2'h0: code = LVL_V43;
                    2'h1: code = seg ? LVL_V5 : LVL_V0;
                    2'h2: code = LVL_V12;
                    default: code = seg ? LVL_V0 : LVL_V5;
                endcase
                if (!blank_n)
                    code = LVL_V5;
            end
            assign codes[2*g +: 2] = code;
        end
    endgenerate
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            o_driver_outputs <= {OUTS{LVL_V5}};
        else
            o_driver_outputs <= codes;
    end
endmodule : lscd_core

// file: lscd_pkg.sv
// Purpose: shared constants and types for the lcd segment/common driver core
// Assumes: one 125 MHz clock, all pin inputs asynchronous to it
// Notes: level codes are abstract selectors for the analog driver stage
package lscd_pkg;
    localparam int OUTS = 160;
    localparam int HALF = 80;
    localparam int GROUP_BITS = 16;
    localparam int BYTES_PER_LINE = 20;
    localparam int SKIP_LO = 60;
    localparam int SKIP_HI = 100;
    localparam logic [1:0] LVL_V0 = 2'h0;
    localparam logic [1:0] LVL_V12 = 2'h1;
    localparam logic [1:0] LVL_V43 = 2'h2;
    localparam logic [1:0] LVL_V5 = 2'h3;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [4:0] BYTE_ZERO = 5'h00;

    typedef enum logic [2:0]
    {
        SEQ_WAIT = 3'b001,
        SEQ_LOAD = 3'b010,
        SEQ_DONE = 3'b100
    } lscd_seq_t;

    typedef struct packed
    {
        logic seg_mode;
        logic dir_right;
        logic width_or_dual;
        logic out120;
    } lscd_mode_t;
endpackage : lscd_pkg

// file: lscd_fifo.sv
// Purpose: small synchronous fifo between byte assembly and data latch
// Assumes: single clock, synchronous active-low reset
// Notes: full and empty are exact; one word in and one out per cycle
`timescale 1ns/1ns
module lscd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_flush,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_bad_depth
        $error("fifo depth must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp;
    logic [AW:0] rp;
    wire do_wr = i_valid && o_ready;
    wire do_rd = o_valid && i_ready;
    assign o_ready = (wp - rp) != (AW+1)'(DEPTH);
    assign o_valid = wp != rp;
    assign o_data = mem[rp[AW-1:0]];
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n || i_flush)
        begin
            wp <= '0;
            rp <= '0;
        end
        else
        begin
            if (do_wr)
                wp <= wp + 1'b1;
            if (do_rd)
                rp <= rp + 1'b1;
        end
    end
    always_ff @(posedge i_clk)
    begin
        if (do_wr)
            mem[wp[AW-1:0]] <= i_data;
    end
endmodule : lscd_fifo

// file: lscd_props.sv
// Purpose: port assertions for lscd_core
// Assumes: one clock, sync active-low reset
// Notes: windows allow for pin synchronisers
`timescale 1ns/1ns
module lscd_props
    import lscd_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_frame_polarity,
    input wire logic i_output_blank_n,
    input wire logic i_line_latch_pulse,
    input wire lscd_pkg::lscd_mode_t i_mode,
    input wire logic o_chain_port_a,
    input wire logic o_chain_port_a_oe,
    input wire logic o_chain_port_b_oe,
    input wire logic [2*lscd_pkg::OUTS-1:0] o_driver_outputs
);
    wire logic [1:0] y1 = o_driver_outputs[1:0];
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    sequence calm(s, f);
        (i_output_blank_n && i_mode.seg_mode == s
            && i_frame_polarity == f) [*6];
    endsequence
    sequence low_run;
        !o_chain_port_a [*5];
    endsequence
    blank_all_a: assert property ((!i_output_blank_n) [*6]
        |-> o_driver_outputs == {OUTS{LVL_V5}}) else $error("blank");
    seg_low_a: assert property (calm(1, 0)
        |-> y1 inside {LVL_V43, LVL_V5}) else $error("seg lo");
    seg_high_a: assert property (calm(1, 1)
        |-> y1 inside {LVL_V12, LVL_V0}) else $error("seg hi");
    com_low_a: assert property (calm(0, 0)
        |-> y1 inside {LVL_V43, LVL_V0}) else $error("com lo");
    com_high_a: assert property (calm(0, 1)
        |-> y1 inside {LVL_V12, LVL_V5}) else $error("com hi");
    hold_a: assert property (($stable(i_line_latch_pulse)
        && i_output_blank_n && $stable(i_frame_polarity)
        && $stable(i_mode)) [*8] |-> $stable(o_driver_outputs))
        else $error("moved");
    port_lo_a: assert property ((!i_mode.dir_right) [*4]
        |-> o_chain_port_a_oe && !o_chain_port_b_oe) else $error("roles");
    port_hi_a: assert property (i_mode.dir_right [*4]
        |-> !o_chain_port_a_oe && o_chain_port_b_oe) else $error("roles");
    chain_pulse_a: assert property ($fell(o_chain_port_a)
        && i_mode.seg_mode && o_chain_port_a_oe
        |-> low_run ##[1:40] o_chain_port_a) else $error("pulse");
endmodule : lscd_props

bind lscd_core lscd_props i_props (
    .i_clk, .i_rst_n, .i_frame_polarity, .i_output_blank_n,
    .i_line_latch_pulse, .i_mode, .o_chain_port_a, .o_chain_port_a_oe,
    .o_chain_port_b_oe, .o_driver_outputs
);

// file: lscd_ctl.sv
// Purpose: controller model on the pixel pins
// Assumes: tasks start just after a rising edge
// Notes: bus shows inverted data between transfers
`timescale 1ns/1ns
module lscd_ctl (
    input wire logic i_clk,
    output logic o_xck = 1'b0,
    output logic o_lp = 1'b0,
    output logic o_sel = 1'b1,
    output logic [7:0] o_data = 8'h00
);
    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_clk);
    endtask : wait_clk
    task automatic set_pins(input logic s, input logic [7:0] d);
        o_sel <= s;
        o_data <= d;
        wait_clk(3);
    endtask : set_pins
    task automatic latch;
        o_lp <= 1'b1;
        wait_clk(4);
        o_lp <= 1'b0;
        wait_clk(4);
    endtask : latch
    task automatic shift(input logic [7:0] d, input logic [7:0] m);
        o_data <= d;
        o_xck <= 1'b1;
        wait_clk(4);
        o_xck <= 1'b0;
        wait_clk(3);
        o_data <= d ^ m;
        wait_clk(1);
    endtask : shift
endmodule : lscd_ctl

// file: lscd_core_bench.sv
// Purpose: random and corner tests of lscd_core
// Assumes: lscd_ctl drives the pixel pins
// Notes: expected codes rebuilt from an image
`timescale 1ns/1ns
module lscd_core_bench;
    import lscd_pkg::*;
    logic i_clk = 1'b0;
    logic rst_n = 1'b0;
    logic fr = 1'b0;
    logic blank_n = 1'b1;
    lscd_mode_t mode = '0;
    logic pixel_shift_clock, lp, sel, pa, pb, pa_oe, pb_oe;
    logic [7:0] data;
    logic [2*OUTS-1:0] outs;
    logic [OUTS:1] img = '0;
    int seed = 50777;
    int fail_count = 0;
    int n_tests = 0;
    wire logic lvl_a = pa_oe ? pa : sel;
    wire logic lvl_b = pb_oe ? pb : sel;
    initial
    begin
        forever #4 i_clk = ~i_clk;
    end
    lscd_ctl i_ctl (.i_clk, .o_xck(pixel_shift_clock), .o_lp(lp), .o_sel(sel), .o_data(data));
    lscd_core i_dut (
        .i_clk, .i_rst_n(rst_n), .i_pixel_shift_clock(pixel_shift_clock),
        .i_line_latch_pulse(lp), .i_frame_polarity(fr),
        .i_output_blank_n(blank_n), .i_pixel_data_in(data), .i_mode(mode),
        .i_chain_port_a(lvl_a), .o_chain_port_a(pa), .o_chain_port_a_oe(pa_oe),
        .i_chain_port_b(lvl_b), .o_chain_port_b(pb), .o_chain_port_b_oe(pb_oe),
        .o_driver_outputs(outs)
    );
    function automatic logic [1:0] lvl(logic b);
        if (!blank_n)
            return LVL_V5;
        if (mode.seg_mode)
            return fr ? (b ? LVL_V0 : LVL_V12) : (b ? LVL_V5 : LVL_V43);
        return fr ? (b ? LVL_V5 : LVL_V12) : (b ? LVL_V0 : LVL_V43);
    endfunction : lvl
    function automatic logic [2*OUTS-1:0] want(logic [OUTS:1] b);
        logic [2*OUTS-1:0] v;
        for (int k = 1; k <= OUTS; k++)
            v[2*k-1 -: 2] = lvl(b[k]);
        return v;
    endfunction : want
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask : tick
    task automatic note(input logic ok, input string m);
        n_tests++;
        if (!ok)
        begin
            fail_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : note
    task automatic check_vec(input logic [2*OUTS-1:0] e, input string m);
        note(outs === e, m);
    endtask : check_vec
    task automatic check_bit(input logic g, e, input string m);
        note(g === e, m);
    endtask : check_bit
    task automatic seg_line(input int w);
        logic [7:0] d;
        logic [7:0] m;
        m = w == 4 ? 8'h0F : 8'hFF;
        i_ctl.latch();
        i_ctl.set_pins(1'b0, 8'h00);
        for (int u = 0; u < OUTS / w; u++)
        begin
            d = 8'($random(seed)) & m;
            for (int i = 0; i < w; i++)
                img[mode.dir_right ? w*(u+1)-i : OUTS-w*(u+1)+1+i] = d[i];
            i_ctl.shift(d, m);
        end
        tick(3);
        check_bit(mode.dir_right ? pb : pa, 1'b0, "chain low");
        i_ctl.shift(~d & m, m);
        tick(3);
        check_bit(mode.dir_right ? pb : pa, 1'b1, "chain high");
        i_ctl.set_pins(1'b1, 8'h00);
        i_ctl.latch();
        tick(4);
        check_vec(want(img), "line");
    endtask : seg_line
    task automatic com_case(input lscd_mode_t md, logic [7:0] d, int k);
        mode <= md;
        fr <= ~fr;
        blank_n <= 1'b0;
        tick(4);
        blank_n <= 1'b1;
        i_ctl.set_pins(1'b1, d);
        i_ctl.latch();
        i_ctl.set_pins(1'b0, 8'h00);
        repeat (k) i_ctl.latch();
        img = '0;
        tick(4);
    endtask : com_case
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up
    initial
    begin
        tick(3);
        #1;
        check_vec({OUTS{LVL_V5}}, "reset codes");
        check_bit(pa, 1'b1, "reset chain");
        check_bit(pa_oe, 1'b0, "reset oe");
        @(posedge i_clk);
        rst_n <= 1'b1;
        tick(3);
        for (int c = 0; c < 4; c++)
        begin
            mode <= {1'b1, c[0], c[1], 1'b0};
            fr <= c[0];
            tick(4);
            if (c == 0)
            begin
                i_ctl.set_pins(1'b0, 8'h00);
                repeat (3) i_ctl.shift(8'h05, 8'h0F);
            end
            seg_line(c[1] ? 8 : 4);
            $display("segment config %0d done", c);
        end
        blank_n <= 1'b0;
        tick(8);
        check_vec(want(img), "blanked");
        seg_line(8);
        blank_n <= 1'b1;
        tick(8);
        check_vec(want('0), "deselect");
        i_ctl.latch();
        tick(4);
        check_vec(want(img), "restored");
        $display("blanking done");
        com_case(4'h0, 8'h00, 5);
        img[155] = 1'b1;
        check_vec(want(img), "single left");
        com_case(4'h5, 8'h00, 60);
        img[101] = 1'b1;
        check_vec(want(img), "skip 120");
        com_case(4'h1, 8'h00, 60);
        img[60] = 1'b1;
        check_vec(want(img), "skip 120 left");
        com_case(4'h7, 8'h80, 2);
        img[3] = 1'b1;
        img[83] = 1'b1;
        check_vec(want(img), "dual");
        com_case(4'h2, 8'h80, 2);
        img[158] = 1'b1;
        img[78] = 1'b1;
        check_vec(want(img), "dual left");
        $display("common mode done");
        wrap_up();
    end
    initial
    begin
        tick(20000);
        fail_count++;
        wrap_up();
    end
endmodule : lscd_core_bench
